// file: design/line_diag_pkg.sv
package line_diag_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PATTERN_ALARM = 8'h0D;
   localparam logic [7:0] IDX_LOOPBACK      = 8'h0E;
   localparam logic [7:0] IDX_CODE_LENGTH   = 8'h0F;
   localparam logic [7:0] IDX_TX_CODE       = 8'h10;
   localparam logic [7:0] IDX_RX_ACTIVATE   = 8'h11;
   localparam logic [7:0] IDX_RX_DEACTIVATE = 8'h12;

   localparam logic [7:0] ADDR_PATTERN_ALARM = 8'(IDX_PATTERN_ALARM * 4);
   localparam logic [7:0] ADDR_LOOPBACK      = 8'(IDX_LOOPBACK * 4);
   localparam logic [7:0] ADDR_CODE_LENGTH   = 8'(IDX_CODE_LENGTH * 4);
   localparam logic [7:0] ADDR_TX_CODE       = 8'(IDX_TX_CODE * 4);
   localparam logic [7:0] ADDR_RX_ACTIVATE   = 8'(IDX_RX_ACTIVATE * 4);
   localparam logic [7:0] ADDR_RX_DEACTIVATE = 8'(IDX_RX_DEACTIVATE * 4);

   // Writable bits of the three masked registers; the rest read as zero
   localparam logic [7:0] MASK_PATTERN_ALARM = 8'h7F;
   localparam logic [7:0] MASK_LOOPBACK      = 8'h0F;
   localparam logic [7:0] MASK_CODE_LENGTH   = 8'h3F;

   // Values after reset
   localparam logic [7:0] RST_PATTERN_ALARM = 8'h00;
   localparam logic [7:0] RST_LOOPBACK      = 8'h00;
   localparam logic [7:0] RST_CODE_LENGTH   = 8'h01;
   localparam logic [7:0] RST_TX_CODE       = 8'h01;
   localparam logic [7:0] RST_RX_ACTIVATE   = 8'h01;
   localparam logic [7:0] RST_RX_DEACTIVATE = 8'h09;

   // Field positions, pattern and alarm register
   localparam int POS_PATTERN_SELECT = 5;
   localparam int POS_PATTERN_CLOCK  = 4;
   localparam int POS_PRBS_INVERT    = 3;
   localparam int POS_LOSS_CRITERION = 2;
   localparam int POS_AIS_ON_LOSS    = 1;
   localparam int POS_AUTO_ALL_ONES  = 0;
   // Field positions, loopback register
   localparam int POS_AUTO_REMOTE    = 3;
   localparam int POS_REMOTE         = 2;
   localparam int POS_ANALOG         = 1;
   localparam int POS_DIGITAL        = 0;
   // Field positions, code length register
   localparam int POS_TX_LENGTH      = 4;
   localparam int POS_RX_ACT_LENGTH  = 2;
   localparam int POS_RX_DEACT_LENGTH = 0;

   // Generator lengths and QRSS zero suppression
   localparam int PRBS_E1_LEN     = 15;
   localparam int QRSS_T1_LEN     = 20;
   localparam int QRSS_ZERO_LIMIT = 14;
   localparam int SYNC_STAGES     = 3;

   typedef enum logic [1:0] {
      PATT_NORMAL = 2'b00,
      PATT_ONES   = 2'b01,
      PATT_PRBS   = 2'b10,
      PATT_CODE   = 2'b11
   } pattern_t;

   // Gray coded along idle -> looped
   typedef enum logic [1:0] {
      LOOP_IDLE   = 2'b00,
      LOOP_ACTIVE = 2'b01
   } auto_loop_t;

endpackage

// file: design/line_diag_maintenance_control.sv
`timescale 1ns/1ns
module line_diag_maintenance_control #(
   parameter int MASTER_BIT_DIV = 49
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Transmit side pins
   input  wire logic        transmit_clock,
   input  wire logic        sys_tx_data,
   // Receive side and mode, same clock domain
   input  wire logic        line_mode_e1,
   input  wire logic        loss_of_signal,
   input  wire logic        rx_bit,
   input  wire logic        rx_bit_valid,
   // Line transmit stream
   output logic             line_tx_data,
   output logic             line_tx_strobe,
   // System receive outputs
   output logic             receive_data_positive,
   output logic             receive_data_negative,
   output logic             receive_clock_out,
   // Status and control to neighbouring blocks
   output logic             analog_loop_active,
   output logic             loss_criterion_select,
   output logic             remote_loop_active,
   output logic             activate_code_seen,
   output logic             deactivate_code_seen,
   output logic             prbs_bit_error
);

   initial begin
      if (MASTER_BIT_DIV < 1 || MASTER_BIT_DIV > 65535) begin
         $error("MASTER_BIT_DIV out of range");
      end
   end

   // Register storage
   logic [7:0] pattern_alarm_reg;
   logic [7:0] loopback_reg;
   logic [7:0] code_length_reg;
   logic [7:0] tx_inband_code_value;
   logic [7:0] rx_activate_code_value;
   logic [7:0] rx_deactivate_code_value;

   line_diag_pkg::pattern_t test_pattern_select;
   logic       pattern_clock_select;
   logic       pseudo_random_invert;
   logic       loss_alarm_criterion;
   logic       alarm_output_on_loss_enable;
   logic       auto_all_ones_on_loss;
   logic       auto_remote_loop_enable;
   logic       remote_loop_enable;
   logic       analog_loop_enable;
   logic       digital_loop_enable;
   logic [1:0] tx_code_length;
   logic [1:0] rx_activate_code_length;
   logic [1:0] rx_deactivate_code_length;

   assign test_pattern_select = line_diag_pkg::pattern_t'(
      pattern_alarm_reg[line_diag_pkg::POS_PATTERN_SELECT +: 2]);
   assign pattern_clock_select        = pattern_alarm_reg[line_diag_pkg::POS_PATTERN_CLOCK];
   assign pseudo_random_invert        = pattern_alarm_reg[line_diag_pkg::POS_PRBS_INVERT];
   assign loss_alarm_criterion        = pattern_alarm_reg[line_diag_pkg::POS_LOSS_CRITERION];
   assign alarm_output_on_loss_enable = pattern_alarm_reg[line_diag_pkg::POS_AIS_ON_LOSS];
   assign auto_all_ones_on_loss       = pattern_alarm_reg[line_diag_pkg::POS_AUTO_ALL_ONES];
   assign auto_remote_loop_enable     = loopback_reg[line_diag_pkg::POS_AUTO_REMOTE];
   assign remote_loop_enable          = loopback_reg[line_diag_pkg::POS_REMOTE];
   assign analog_loop_enable          = loopback_reg[line_diag_pkg::POS_ANALOG];
   assign digital_loop_enable         = loopback_reg[line_diag_pkg::POS_DIGITAL];
   assign tx_code_length            = code_length_reg[line_diag_pkg::POS_TX_LENGTH +: 2];
   assign rx_activate_code_length   = code_length_reg[line_diag_pkg::POS_RX_ACT_LENGTH +: 2];
   assign rx_deactivate_code_length = code_length_reg[line_diag_pkg::POS_RX_DEACT_LENGTH +: 2];

   // Code length field to period minus one: 00..11 give 5..8 bits
   function automatic logic [2:0] code_last(input logic [1:0] len);
      code_last = 3'(len) + 3'h4;
   endfunction

   // Repeated-code match: two back-to-back copies of the low bits
   function automatic logic code_match(input logic [15:0] hist,
                                       input logic [7:0]  code,
                                       input logic [1:0]  len);
      logic [7:0] mask;
      logic [7:0] first;
      logic [7:0] second;
      mask   = 8'hFF >> (3'h3 - 3'(len));
      first  = hist[7:0] & mask;
      second = 8'(hist >> (4'(len) + 4'h5)) & mask;
      code_match = (first == (code & mask)) && (second == (code & mask));
   endfunction

   // APB slave: answer one cycle after setup
   logic       apb_setup;
   logic       apb_write_now;
   logic [7:0] next_rdata;
   logic       next_err;

   assign apb_setup     = psel && !penable && !pready;
   assign apb_write_now = psel && penable && pready && pwrite && pstrb[0];

   always_comb begin
      next_rdata = 8'h00;
      next_err   = 1'b0;
      if (paddr == line_diag_pkg::ADDR_PATTERN_ALARM) begin
         next_rdata = pattern_alarm_reg;
      end else if (paddr == line_diag_pkg::ADDR_LOOPBACK) begin
         next_rdata = loopback_reg;
      end else if (paddr == line_diag_pkg::ADDR_CODE_LENGTH) begin
         next_rdata = code_length_reg;
      end else if (paddr == line_diag_pkg::ADDR_TX_CODE) begin
         next_rdata = tx_inband_code_value;
      end else if (paddr == line_diag_pkg::ADDR_RX_ACTIVATE) begin
         next_rdata = rx_activate_code_value;
      end else if (paddr == line_diag_pkg::ADDR_RX_DEACTIVATE) begin
         next_rdata = rx_deactivate_code_value;
      end else begin
         next_err = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (apb_setup) begin
         pready  <= 1'b1;
         pslverr <= next_err;
         prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pattern_alarm_reg        <= line_diag_pkg::RST_PATTERN_ALARM;
         loopback_reg             <= line_diag_pkg::RST_LOOPBACK;
         code_length_reg          <= line_diag_pkg::RST_CODE_LENGTH;
         tx_inband_code_value     <= line_diag_pkg::RST_TX_CODE;
         rx_activate_code_value   <= line_diag_pkg::RST_RX_ACTIVATE;
         rx_deactivate_code_value <= line_diag_pkg::RST_RX_DEACTIVATE;
      end else if (apb_write_now) begin
         if (paddr == line_diag_pkg::ADDR_PATTERN_ALARM) begin
            pattern_alarm_reg <= pwdata[7:0] & line_diag_pkg::MASK_PATTERN_ALARM;
         end else if (paddr == line_diag_pkg::ADDR_LOOPBACK) begin
            loopback_reg <= pwdata[7:0] & line_diag_pkg::MASK_LOOPBACK;
         end else if (paddr == line_diag_pkg::ADDR_CODE_LENGTH) begin
            code_length_reg <= pwdata[7:0] & line_diag_pkg::MASK_CODE_LENGTH;
         end else if (paddr == line_diag_pkg::ADDR_TX_CODE) begin
            tx_inband_code_value <= pwdata[7:0];
         end else if (paddr == line_diag_pkg::ADDR_RX_ACTIVATE) begin
            rx_activate_code_value <= pwdata[7:0];
         end else if (paddr == line_diag_pkg::ADDR_RX_DEACTIVATE) begin
            rx_deactivate_code_value <= pwdata[7:0];
         end
      end
   end

   // Pin synchronisers; a change counts once stages two and three agree
   logic [line_diag_pkg::SYNC_STAGES-1:0] transmit_clock_sync;
   logic [line_diag_pkg::SYNC_STAGES-1:0] txd_sync;
   logic                                  transmit_clock_level;
   logic                                  transmit_clock_prev;
   logic                                  txd_level;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         transmit_clock_sync <= '0;
         txd_sync  <= '0;
      end else begin
         transmit_clock_sync <= {transmit_clock_sync[1:0], transmit_clock};
         txd_sync  <= {txd_sync[1:0], sys_tx_data};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         transmit_clock_level <= 1'b0;
         transmit_clock_prev  <= 1'b0;
         txd_level  <= 1'b0;
      end else begin
         transmit_clock_prev <= transmit_clock_level;
         if (transmit_clock_sync[1] == transmit_clock_sync[2]) begin
            transmit_clock_level <= transmit_clock_sync[2];
         end
         if (txd_sync[1] == txd_sync[2]) begin
            txd_level <= txd_sync[2];
         end
      end
   end

   // Bit ticks: transmit clock edge or divided master clock
   logic        tx_clock_tick;
   logic        master_tick;
   logic [15:0] master_count;
   logic        bit_tick;

   assign tx_clock_tick = transmit_clock_level && !transmit_clock_prev;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         master_count <= 16'h0000;
         master_tick  <= 1'b0;
      end else if (master_count == 16'(MASTER_BIT_DIV - 1)) begin
         master_count <= 16'h0000;
         master_tick  <= 1'b1;
      end else begin
         master_count <= master_count + 16'h0001;
         master_tick  <= 1'b0;
      end
   end

   // Master tick whenever selected, normal data included
   assign bit_tick = (test_pattern_select != line_diag_pkg::PATT_NORMAL && pattern_clock_select)
                     || (test_pattern_select == line_diag_pkg::PATT_NORMAL && pattern_clock_select)
                     ? master_tick : tx_clock_tick;

   // Pseudo-random generator: x^15+x^14+1 or x^20+x^17+1
   logic [19:0] prbs_state;
   logic        prbs_feedback;
   logic [3:0]  zero_run;
   logic        prbs_raw;

   assign prbs_feedback = line_mode_e1 ? (prbs_state[14] ^ prbs_state[13])
                                       : (prbs_state[19] ^ prbs_state[16]);
   // QRSS forces a one after a long zero run
   assign prbs_raw = line_mode_e1 ? prbs_state[14]
                     : (prbs_state[19] || zero_run == 4'(line_diag_pkg::QRSS_ZERO_LIMIT));

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prbs_state <= 20'h0_0001;
         zero_run   <= 4'h0;
      end else if (bit_tick && test_pattern_select == line_diag_pkg::PATT_PRBS) begin
         prbs_state <= {prbs_state[18:0], prbs_feedback};
         if (prbs_raw) begin
            zero_run <= 4'h0;
         end else begin
            zero_run <= zero_run + 4'h1;
         end
      end
   end

   // Inband code generator walks the low code bits, MSB first
   logic [2:0] code_pos;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         code_pos <= 3'h4;
      end else if (bit_tick && test_pattern_select == line_diag_pkg::PATT_CODE) begin
         if (code_pos == 3'h0) begin
            code_pos <= code_last(tx_code_length);
         end else begin
            code_pos <= code_pos - 3'h1;
         end
      end
   end

   // Auto remote loopback follows received inband codes
   logic [15:0]               rx_history;
   logic                      act_hit;
   logic                      deact_hit;
   line_diag_pkg::auto_loop_t auto_loop_state;
   logic                      effective_remote;

   assign act_hit   = code_match(rx_history, rx_activate_code_value,
                                 rx_activate_code_length);
   assign deact_hit = code_match(rx_history, rx_deactivate_code_value,
                                 rx_deactivate_code_length);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_history <= 16'h0000;
      end else if (rx_bit_valid) begin
         rx_history <= {rx_history[14:0], rx_bit};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         auto_loop_state <= line_diag_pkg::LOOP_IDLE;
      end else if (!auto_remote_loop_enable) begin
         auto_loop_state <= line_diag_pkg::LOOP_IDLE;
      end else begin
         case (auto_loop_state)
            line_diag_pkg::LOOP_IDLE: begin
               if (act_hit) begin
                  auto_loop_state <= line_diag_pkg::LOOP_ACTIVE;
               end
            end
            line_diag_pkg::LOOP_ACTIVE: begin
               if (deact_hit) begin
                  auto_loop_state <= line_diag_pkg::LOOP_IDLE;
               end
            end
            default: begin
               auto_loop_state <= line_diag_pkg::LOOP_IDLE;
            end
         endcase
      end
   end

   assign effective_remote = remote_loop_enable
                             || auto_loop_state == line_diag_pkg::LOOP_ACTIVE;

   // Transmit bit selection; loss all-ones wins only in normal mode
   logic next_tx_bit;
   logic next_tx_strobe;

   always_comb begin
      next_tx_bit    = txd_level;
      next_tx_strobe = bit_tick;
      if (effective_remote) begin
         next_tx_bit    = rx_bit;
         next_tx_strobe = rx_bit_valid;
      end else begin
         case (test_pattern_select)
            line_diag_pkg::PATT_NORMAL: begin
               next_tx_bit = pattern_clock_select ? 1'b0 : txd_level;
               if (auto_all_ones_on_loss && loss_of_signal) begin
                  next_tx_bit = 1'b1;
               end
            end
            line_diag_pkg::PATT_ONES: begin
               next_tx_bit = 1'b1;
            end
            line_diag_pkg::PATT_PRBS: begin
               next_tx_bit = prbs_raw ^ pseudo_random_invert;
            end
            line_diag_pkg::PATT_CODE: begin
               next_tx_bit = tx_inband_code_value[code_pos];
            end
            default: begin
               next_tx_bit = txd_level;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_tx_data   <= 1'b0;
         line_tx_strobe <= 1'b0;
      end else begin
         line_tx_data   <= next_tx_bit;
         line_tx_strobe <= next_tx_strobe;
      end
   end

   // Receive-side PRBS checker, self-synchronising on received bits
   logic [19:0] chk_state;
   logic        chk_bit;
   logic        chk_expect;

   assign chk_bit    = rx_bit ^ pseudo_random_invert;
   assign chk_expect = line_mode_e1 ? (chk_state[14] ^ chk_state[13])
                                    : (chk_state[19] ^ chk_state[16]);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         chk_state      <= 20'h0_0000;
         prbs_bit_error <= 1'b0;
      end else if (rx_bit_valid) begin
         chk_state      <= {chk_state[18:0], chk_bit};
         prbs_bit_error <= (chk_bit != chk_expect);
      end else begin
         prbs_bit_error <= 1'b0;
      end
   end

   // System receive outputs: recovered data, digital loop, or alarm
   always_ff @(posedge core_clk) begin
      if (rst) begin
         receive_data_positive <= 1'b0;
         receive_data_negative <= 1'b0;
         receive_clock_out     <= 1'b0;
      end else if (alarm_output_on_loss_enable && loss_of_signal) begin
         // Alarm pattern is all ones, clocked from the master tick
         if (master_tick) begin
            receive_data_positive <= 1'b1;
            receive_data_negative <= 1'b0;
            receive_clock_out     <= !receive_clock_out;
         end
      end else if (digital_loop_enable) begin
         if (tx_clock_tick) begin
            receive_data_positive <= txd_level;
            receive_data_negative <= !txd_level;
            receive_clock_out     <= !receive_clock_out;
         end
      end else if (rx_bit_valid) begin
         receive_data_positive <= rx_bit;
         receive_data_negative <= !rx_bit;
         receive_clock_out     <= !receive_clock_out;
      end
   end

   // Status and steering outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         analog_loop_active    <= 1'b0;
         loss_criterion_select <= 1'b0;
         remote_loop_active    <= 1'b0;
         activate_code_seen    <= 1'b0;
         deactivate_code_seen  <= 1'b0;
      end else begin
         analog_loop_active    <= analog_loop_enable;
         loss_criterion_select <= loss_alarm_criterion;
         remote_loop_active    <= effective_remote;
         activate_code_seen    <= act_hit;
         deactivate_code_seen  <= deact_hit;
      end
   end

endmodule

// file: dv/line_diag_props.sv
`timescale 1ns/1ns
module line_diag_props (
   // Bus, clock and reset
   input logic        core_clk, rst, psel, penable, pwrite, pready, pslverr,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic [31:0] prdata,
   // Line and status
   input logic        loss_of_signal, line_tx_data, line_tx_strobe, receive_data_positive,
   input logic        receive_data_negative, analog_loop_active, loss_criterion_select,
   input logic        remote_loop_active
);
   logic [7:0] pa, lb;
   logic [3:0] age;
   wire        wr = psel && penable && pready && pwrite && pstrb[0];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Cycles since last write; line outputs lag the registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pa  <= 8'h00;
         lb  <= 8'h00;
         age <= 4'h0;
      end else begin
         age <= wr ? 4'h0 : age + 4'(age != 4'hF);
         if (wr && paddr == line_diag_pkg::ADDR_PATTERN_ALARM) pa <= pwdata[7:0];
         if (wr && paddr == line_diag_pkg::ADDR_LOOPBACK) lb <= pwdata[7:0];
      end
   end
   property p_rdata; pready && !pwrite |-> prdata[31:8] == 24'h00_0000; endproperty
   a_rdata: assert property (p_rdata) else $error("read data high bits");
   property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
   a_err: assert property (p_err) else $error("error answer");
   property p_analog; age > 4'h3 |-> analog_loop_active == lb[1]; endproperty
   a_analog: assert property (p_analog) else $error("analog loop");
   property p_crit; age > 4'h3 |-> loss_criterion_select == pa[2]; endproperty
   a_crit: assert property (p_crit) else $error("loss criterion");
   property p_remote; age > 4'h3 && lb[2] |-> remote_loop_active; endproperty
   a_remote: assert property (p_remote) else $error("remote loop");
   property p_ones;
      line_tx_strobe && age == 4'hF && pa[6:5] == 2'b01 && !remote_loop_active |-> line_tx_data;
   endproperty
   a_ones: assert property (p_ones) else $error("ones pattern");
   property p_zero;
      line_tx_strobe && age == 4'hF && pa[6:4] == 3'b001 && !pa[0] && !remote_loop_active
      |-> !line_tx_data;
   endproperty
   a_zero: assert property (p_zero) else $error("zero pattern");
   property p_ais;
      (age == 4'hF && pa[1] && loss_of_signal) [*8]
      |-> receive_data_positive && !receive_data_negative;
   endproperty
   a_ais: assert property (p_ais) else $error("alarm output");
endmodule

bind line_diag_maintenance_control line_diag_props i_props (
   .core_clk, .rst, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .pstrb,
   .prdata, .loss_of_signal, .line_tx_data, .line_tx_strobe, .receive_data_positive,
   .receive_data_negative, .analog_loop_active, .loss_criterion_select, .remote_loop_active);

// file: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic        transmit_clock = 0, loss_of_signal = 0, rx_bit_valid = 0;
   logic        sys_tx_data = 0, rx_bit = 0, line_mode_e1 = 1, receive_clock_out;
   logic        activate_code_seen, deactivate_code_seen, prbs_bit_error;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, r;
   logic        pready, pslverr, line_tx_data, line_tx_strobe, receive_data_positive;
   logic        receive_data_negative, analog_loop_active, loss_criterion_select;
   logic        remote_loop_active, e, ok;
   logic [2:0]  tdiv = 3'h0;
   logic [15:0] w, m, c;
   logic [7:0]  ad [6], rv [6], mk [6];
   int          fail_count = 0, check_count = 0;

   always #5 core_clk = ~core_clk;
   // Bit clock and receive strobe at an eighth of the core rate
   always @(posedge core_clk) begin
      tdiv           <= tdiv + 3'h1;
      transmit_clock <= tdiv[2];
      rx_bit_valid   <= tdiv == 3'h0;
   end
   line_diag_maintenance_control #(.MASTER_BIT_DIV(4)) i_dut (
      .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
      .pready, .pslverr, .transmit_clock, .sys_tx_data, .line_mode_e1,
      .loss_of_signal, .rx_bit, .rx_bit_valid, .line_tx_data, .line_tx_strobe,
      .receive_data_positive, .receive_data_negative, .receive_clock_out, .analog_loop_active,
      .loss_criterion_select, .remote_loop_active, .activate_code_seen,
      .deactivate_code_seen, .prbs_bit_error);

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) fail_count++;
      if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
   endtask
   task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= wr_en;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge core_clk);
      if (n == 20) fail_count++;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Four bits skipped first, so stale bits of the last pattern drop out
   task bits(input int cnt);
      int k;
      w = 16'h0000;
      repeat (cnt + 4) begin
         @(posedge core_clk);
         for (k = 0; k < 40 && line_tx_strobe !== 1'b1; k++) @(posedge core_clk);
         w = {w[14:0], line_tx_data};
      end
   endtask
   task conclude();
      $display("checks %0d fails %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100_000;
      fail_count++;
      conclude();
   end

   initial begin
      ad = '{8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48};
      rv = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h09};
      mk = '{8'h7F, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ad[i], 32'h0000_0000);
         chk(r, {24'h00_0000, rv[i]});
         apb(1'b1, ad[i], 32'hFFFF_FFFF);
         apb(1'b0, ad[i], 32'h0000_0000);
         chk(r, {24'h00_0000, mk[i]});
      end
      r = 32'({analog_loop_active, remote_loop_active, loss_criterion_select});
      chk(r, 32'h0000_0007);
      apb(1'b0, 8'h4C, 32'h0000_0000);
      chk({e, r[30:0]}, 32'h8000_0000);
      apb(1'b1, ad[1], 32'h0000_0000);
      apb(1'b1, ad[0], 32'h0000_0020);
      bits(8);
      chk(w[7:0], 8'hFF);
      // Transmit clock bit period is eight core cycles
      repeat (4) @(posedge core_clk);
      chk(line_tx_strobe, 1'b0);
      repeat (4) @(posedge core_clk);
      chk(line_tx_strobe, 1'b1);
      apb(1'b1, ad[0], 32'h0000_0010);
      bits(8);
      chk(w[7:0], 8'h00);
      // Master tick period equals the divider chosen above
      repeat (4) @(posedge core_clk);
      chk(line_tx_strobe, 1'b1);
      loss_of_signal <= 1'b1;
      apb(1'b1, ad[0], 32'h0000_0013);
      bits(8);
      chk(w[7:0], 8'hFF);
      chk({receive_data_positive, receive_data_negative}, 2'b10);
      loss_of_signal <= 1'b0;
      sys_tx_data    <= 1'b1;
      apb(1'b1, ad[1], 32'h0000_0001);
      apb(1'b1, ad[0], 32'h0000_0000);
      bits(8);
      chk(w[7:0], 8'hFF);
      chk({receive_data_positive, receive_data_negative}, 2'b10);
      e = receive_clock_out;
      repeat (8) @(posedge core_clk);
      chk(receive_clock_out, !e);
      sys_tx_data <= 1'b0;
      apb(1'b1, ad[1], 32'h0000_0000);
      // Bit n of the sequence is bit n-14 xor bit n-15
      apb(1'b1, ad[0], 32'h0000_0040);
      bits(16);
      chk(w[0] ^ w[14] ^ w[15], 1'b0);
      apb(1'b1, ad[0], 32'h0000_0048);
      bits(16);
      chk(w[0] ^ w[14] ^ w[15], 1'b1);
      for (int k = 0; k < 20 && prbs_bit_error !== 1'b1; k++) @(posedge core_clk);
      chk(prbs_bit_error, 1'b1);
      apb(1'b1, ad[3], 32'h0000_00A6);
      apb(1'b1, ad[0], 32'h0000_0060);
      for (int k = 5; k < 9; k++) begin
         apb(1'b1, ad[2], 32'((k - 5) * 16));
         bits(2 * k);
         m  = (16'h0001 << k) - 16'h0001;
         c  = 16'h00A6 & m;
         ok = 1'b0;
         for (int s = 0; s < k; s++) ok |= (w & m) == (((c >> s) | (c << (k - s))) & m);
         chk({ok, (w >> k) & m}, {1'b1, w & m});
      end
      // Five ones twice engage the loop, five zeros twice release it
      apb(1'b1, ad[5], 32'h0000_0000);
      apb(1'b1, ad[1], 32'h0000_0008);
      rx_bit <= 1'b1;
      repeat (120) @(posedge core_clk);
      chk({remote_loop_active, activate_code_seen}, 2'b11);
      bits(4);
      chk(w[7:0], 8'hFF);
      rx_bit <= 1'b0;
      repeat (120) @(posedge core_clk);
      chk({remote_loop_active, deactivate_code_seen}, 2'b01);
      conclude();
   end
endmodule
